/* File: core/sbcp_top.sv */
// Baud prescaler, bit-rate divider and synchronous clock edge selection
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "sbcp_regs.svh"
module sbcp_top
    import sbcp_pkg::*;
#(
    parameter int DIV_W = 12
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [1:0]  MODE,
    input  wire logic        DOUBLE_SPEED,
    input  wire logic        TX_DATA,
    output logic             SERIAL_TX,
    input  wire logic        SERIAL_RX,
    input  wire logic        SYNC_CLOCK_I,
    output logic             SYNC_CLOCK_O,
    output logic             SYNC_CLOCK_OE,
    output logic             BAUD_TICK,
    output logic             BIT_TICK,
    output logic             TX_LAUNCH,
    output logic             RX_SAMPLE,
    output logic             RX_BIT
);
    localparam int HI_W = DIV_W - 8;

    // Status packing leaves bits 15:DIV_W free, so 15 is the limit
    if (DIV_W < 9 || DIV_W > 15) begin : g_chk
        $error("DIV_W must lie between 9 and 15");
    end

    logic [HI_W-1:0]  div_hi_ff;
    logic [7:0]       div_lo_ff;
    sbcp_ctrl_t       ctrl_ff;
    logic [DIV_W-1:0] presc_ff;
    logic [DIV_W-1:0] nxt_presc;
    logic [3:0]       bit_cnt_ff;
    logic [3:0]       nxt_bit_cnt;
    logic             xck_ff;
    logic             nxt_xck;
    logic             xs1_ff;
    logic             xs2_ff;
    logic             xs3_ff;
    logic             xf_ff;
    logic             rs1_ff;
    logic             rs2_ff;
    logic             rs3_ff;
    logic             rxf_ff;
    logic             pready_ff;
    logic [31:0]      prdata_ff;
    logic             pslverr_ff;
    logic             tick_ff;
    logic             bit_ff;
    logic             launch_ff;
    logic             sample_ff;
    logic             tx_ff;
    logic             rxbit_ff;
    logic             oe_ff;

    // Bus decode
    wire apb_setup = PSEL & PENABLE & ~pready_ff;
    wire apb_done  = PSEL & PENABLE & pready_ff;
    wire wr_en     = apb_done & PWRITE;
    wire hit_hi    = PADDR == `SBCP_OFS_DIV_HI;
    wire hit_lo    = PADDR == `SBCP_OFS_DIV_LO;
    wire hit_ctrl  = PADDR == `SBCP_OFS_CTRL;
    wire hit_stat  = PADDR == `SBCP_OFS_STAT;
    wire hit_any   = hit_hi | hit_lo | hit_ctrl | hit_stat;
    wire hi_write  = wr_en & hit_hi;
    wire lo_write  = wr_en & hit_lo;
    wire ctrl_write = wr_en & hit_ctrl;

    wire [DIV_W-1:0] divisor = {div_hi_ff, div_lo_ff};
    wire [DIV_W-1:0] new_div = {div_hi_ff, PWDATA[7:0]};
    wire sbcp_ctrl_t wr_ctrl = '{master:   PWDATA[`SBCP_CTRL_MST_BIT],
                                 polarity: PWDATA[`SBCP_CTRL_POL_BIT]};

    // Mode selection
    wire sbcp_mode_t mode = sbcp_mode_t'(MODE);
    wire sync_mode = (mode == SBCP_SYNC) | (mode == SBCP_MSPI);
    wire master_on = sync_mode & ctrl_ff.master;
    wire clk_lvl   = master_on ? xck_ff : xf_ff;

    // Prescaler
    wire presc_zero = presc_ff == '0;
    wire base_tick  = presc_zero & ~lo_write;
    // Low write restarts the period; the tick of that cycle is dropped
    assign nxt_presc = lo_write   ? new_div :
                       presc_zero ? divisor :
                       presc_ff - 1'b1;

    // Bit-rate divider, async only
    wire [4:0] tpb = (DOUBLE_SPEED & ~sync_mode) ? `SBCP_TICKS_DOUBLE
                                                 : `SBCP_TICKS_NORMAL;
    // Switching to double speed mid-count must not overrun the counter
    wire bit_last = {1'b0, bit_cnt_ff} >= (tpb - 5'h01);
    assign nxt_bit_cnt = ~base_tick ? bit_cnt_ff :
                         bit_last   ? 4'h0 : bit_cnt_ff + 4'h1;
    wire async_bit = ~sync_mode & base_tick & bit_last;

    // Clock edges: master from own divider, slave from filtered pin
    wire xs_agree = xs2_ff == xs3_ff;
    wire rx_agree = rs2_ff == rs3_ff;
    sbcp_edges_t edg;
    assign edg.rise = master_on ? (base_tick & ~xck_ff)
                                : (xs_agree & xs3_ff & ~xf_ff);
    assign edg.fall = master_on ? (base_tick & xck_ff)
                                : (xs_agree & ~xs3_ff & xf_ff);
    assign nxt_xck = master_on ? (xck_ff ^ base_tick) : 1'b0;

    // Polarity picks launch and sample edges; async ignores it
    wire launch = sync_mode ? (ctrl_ff.polarity ? edg.fall : edg.rise)
                            : async_bit;
    wire sample = sync_mode & (ctrl_ff.polarity ? edg.rise
                                                : edg.fall);

    // Read data
    wire [31:0] rd_hi   = {{(40-DIV_W){1'b0}}, div_hi_ff};
    wire [31:0] rd_lo   = {24'h000000, div_lo_ff};
    wire [31:0] rd_ctrl = {30'h00000000, ctrl_ff};
    wire [31:0] rd_stat = {14'h0000, clk_lvl, rxf_ff,
                           {(16-DIV_W){1'b0}}, presc_ff};
    wire [31:0] rd_mux  = hit_hi   ? rd_hi   :
                          hit_lo   ? rd_lo   :
                          hit_ctrl ? rd_ctrl :
                          hit_stat ? rd_stat : 32'h00000000;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= apb_setup;
            prdata_ff  <= apb_setup & ~PWRITE ? rd_mux : 32'h00000000;
            pslverr_ff <= apb_setup & ~hit_any;
        end
    end

    // Upper bits of the high write are dropped, not stored
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            div_hi_ff <= HI_W'(`SBCP_RST_DIV_HI);
            div_lo_ff <= `SBCP_RST_DIV_LO;
            ctrl_ff   <= `SBCP_RST_CTRL;
        end else begin
            if (hi_write) div_hi_ff <= PWDATA[HI_W-1:0];
            if (lo_write) div_lo_ff <= PWDATA[7:0];
            if (ctrl_write) ctrl_ff <= wr_ctrl;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            presc_ff   <= '0;
            bit_cnt_ff <= 4'h0;
            xck_ff     <= 1'b0;
            oe_ff      <= 1'b0;
        end else begin
            presc_ff   <= nxt_presc;
            bit_cnt_ff <= nxt_bit_cnt;
            xck_ff     <= nxt_xck;
            oe_ff      <= master_on;
        end
    end

    // Pin synchronisers, three stages; a change counts once 2 and 3 agree
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            {xs1_ff, xs2_ff, xs3_ff, xf_ff} <= 4'h0;
            {rs1_ff, rs2_ff, rs3_ff, rxf_ff} <= 4'hf;
        end else begin
            {xs1_ff, xs2_ff, xs3_ff} <= {SYNC_CLOCK_I, xs1_ff, xs2_ff};
            {rs1_ff, rs2_ff, rs3_ff} <= {SERIAL_RX, rs1_ff, rs2_ff};
            if (xs_agree) xf_ff <= xs3_ff;
            if (rx_agree) rxf_ff <= rs3_ff;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tick_ff   <= 1'b0;
            bit_ff    <= 1'b0;
            launch_ff <= 1'b0;
            sample_ff <= 1'b0;
            tx_ff     <= 1'b1;
            rxbit_ff  <= 1'b1;
        end else begin
            tick_ff   <= base_tick;
            bit_ff    <= launch;
            launch_ff <= launch;
            sample_ff <= sample;
            if (launch) tx_ff <= TX_DATA;
            if (sample) rxbit_ff <= rxf_ff;
        end
    end

    assign PRDATA        = prdata_ff;
    assign PREADY        = pready_ff;
    assign PSLVERR       = pslverr_ff;
    assign SERIAL_TX     = tx_ff;
    assign SYNC_CLOCK_O  = xck_ff;
    assign SYNC_CLOCK_OE = oe_ff;
    assign BAUD_TICK     = tick_ff;
    assign BIT_TICK      = bit_ff;
    assign TX_LAUNCH     = launch_ff;
    assign RX_SAMPLE     = sample_ff;
    assign RX_BIT        = rxbit_ff;

    // Checking helpers: base ticks seen since the last BIT_TICK, async bit or sync launch
    logic [4:0] hlp_cnt_ff;
    logic       hlp_ok_ff;
    logic [1:0] hlp_cfg_ff;
    wire  [1:0] hlp_cfg = {DOUBLE_SPEED, sync_mode};
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            hlp_cnt_ff <= 5'h00;
            hlp_ok_ff  <= 1'b0;
            hlp_cfg_ff <= 2'h0;
        end else begin
            hlp_cfg_ff <= hlp_cfg;
            if (BIT_TICK) hlp_cnt_ff <= 5'h00;
            else if (BAUD_TICK) hlp_cnt_ff <= hlp_cnt_ff + 5'h01;
            if (hlp_cfg != hlp_cfg_ff) hlp_ok_ff <= 1'b0;
            else if (BIT_TICK) hlp_ok_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    a_zero_div_tick: assert property (
        (divisor == '0 && presc_ff == '0 && !lo_write)[*2] |=> BAUD_TICK)
        else $error("Zero divisor did not tick every cycle");
    a_low_reload: assert property (
        lo_write |=> presc_ff == $past(new_div) && !BAUD_TICK)
        else $error("Low write did not reload prescaler");
    a_tick_period: assert property (
        BAUD_TICK && divisor == 3 && !lo_write
        ##1 (divisor == 3 && !lo_write)[*3] |-> ##1 BAUD_TICK)
        else $error("Divisor 3 did not tick every 4 clocks");
    // The reload takes the divisor of the tick's own cycle, one back
    a_tick_gap: assert property (
        BAUD_TICK && $past(divisor) != '0 |=> !BAUD_TICK)
        else $error("Base ticks too close for nonzero divisor");
    a_bit_rate: assert property (
        BIT_TICK && hlp_ok_ff && !hlp_cfg_ff[0] |->
        hlp_cnt_ff == (hlp_cfg_ff[1] ? 5'h07 : 5'h0f))
        else $error("Async bit tick at wrong base tick count");
    a_launch_edge: assert property (
        TX_LAUNCH && SYNC_CLOCK_OE && $past(SYNC_CLOCK_OE)
        && $stable(ctrl_ff) |->
        $changed(SYNC_CLOCK_O) && SYNC_CLOCK_O == !ctrl_ff.polarity)
        else $error("Transmit launched on wrong clock edge");
    a_sample_edge: assert property (
        RX_SAMPLE && SYNC_CLOCK_OE && $past(SYNC_CLOCK_OE)
        && $stable(ctrl_ff) |->
        $changed(SYNC_CLOCK_O) && SYNC_CLOCK_O == ctrl_ff.polarity)
        else $error("Receive sampled on wrong clock edge");
    a_tx_data: assert property (
        TX_LAUNCH |-> SERIAL_TX == $past(TX_DATA))
        else $error("Transmit pin did not take launched data");
    a_hi_reserved: assert property (
        PREADY && !PWRITE && hit_hi |-> PRDATA[31:HI_W] == '0)
        else $error("Reserved high bits read nonzero");
    a_div_split: assert property (
        hi_write |=> divisor[DIV_W-1:8] == $past(PWDATA[HI_W-1:0]))
        else $error("High write did not land in divisor top bits");
    a_bus_error: assert property (
        PREADY |-> PSLVERR == !hit_any && (hit_any || PRDATA == '0))
        else $error("Slave error or read data wrong for address");
    a_async_nosample: assert property (
        !$past(sync_mode) |-> !RX_SAMPLE)
        else $error("Receive sampled outside synchronous mode");
    a_slave_edge: assert property (
        TX_LAUNCH && !SYNC_CLOCK_OE && $past(sync_mode)
        && $stable(ctrl_ff) |-> $changed(xf_ff)
        && xf_ff == !ctrl_ff.polarity)
        else $error("Slave launch not on the selected pin edge");
    a_oe_master: assert property (
        SYNC_CLOCK_OE == $past(master_on))
        else $error("Clock pin enable does not follow master setting");

    c_zero_div: cover property (divisor == '0 && BAUD_TICK [*3]);
    c_double_bit: cover property (BIT_TICK && hlp_ok_ff && hlp_cfg_ff[1]);
    c_pol_one: cover property (TX_LAUNCH && SYNC_CLOCK_OE
                               && ctrl_ff.polarity);
    c_low_reload: cover property (lo_write ##1 presc_ff != '0);
    c_slave_launch: cover property (TX_LAUNCH && !SYNC_CLOCK_OE
                                    && $past(sync_mode));
endmodule // sbcp_top

/* File: shared/sbcp_pkg.sv */
// Types shared by the baud and clock polarity block
package sbcp_pkg;
    typedef enum logic [1:0] {
        SBCP_ASYNC, SBCP_SYNC, SBCP_RSVD, SBCP_MSPI
    } sbcp_mode_t;
    typedef struct packed {
        logic master;
        logic polarity;
    } sbcp_ctrl_t;
    typedef struct packed {
        logic rise;
        logic fall;
    } sbcp_edges_t;
endpackage

/* File: shared/sbcp_regs.svh */
// Register offsets, field positions, reset values and bit-rate counts
`ifndef SBCP_REGS_SVH
`define SBCP_REGS_SVH
`define SBCP_OFS_DIV_HI    12'h000
`define SBCP_OFS_DIV_LO    12'h004
`define SBCP_OFS_CTRL      12'h008
`define SBCP_OFS_STAT      12'h00c
`define SBCP_CTRL_POL_BIT  0
`define SBCP_CTRL_MST_BIT  1
`define SBCP_STAT_RX_BIT   16
`define SBCP_STAT_CLK_BIT  17
`define SBCP_RST_DIV_HI    8'h00
`define SBCP_RST_DIV_LO    8'h00
`define SBCP_RST_CTRL      2'h0
`define SBCP_TICKS_NORMAL  5'h10
`define SBCP_TICKS_DOUBLE  5'h08
`endif

/* File: verification/sbcp_partner.sv */
// Remote serial device model facing the sync clock and receive pin
`timescale 1ns/1ns
module sbcp_partner (
    input  wire logic CLOCK,
    input  wire logic RST,
    input  wire logic SYNC_CLOCK_O,
    input  wire logic SYNC_CLOCK_OE,
    input  wire logic POLARITY,
    input  wire logic RUN_CLOCK,
    output logic      SERIAL_RX,
    output logic      SYNC_CLOCK_I
);
    logic       clk_prev_ff;
    logic       data_ff;
    logic       own_clk_ff;
    logic [2:0] div_ff;
    // Pin level both sides see: the block's clock while it masters
    wire        pin_clk = SYNC_CLOCK_OE ? SYNC_CLOCK_O : own_clk_ff;
    // A released receive line floats to its pull-up level
    assign SERIAL_RX    = (SYNC_CLOCK_OE | RUN_CLOCK) ? data_ff : 1'b1;
    // Own clock runs only while a slave frame is wanted, low otherwise
    assign SYNC_CLOCK_I = own_clk_ff;
    always_ff @(posedge CLOCK) begin
        clk_prev_ff <= pin_clk;
        if (RST) begin
            data_ff    <= 1'b0;
            own_clk_ff <= 1'b0;
            div_ff     <= 3'h0;
        end else begin
            div_ff <= RUN_CLOCK ? div_ff + 3'h1 : 3'h0;
            // Eight clocks per half period outlast the pin filter delay
            if (!RUN_CLOCK) own_clk_ff <= 1'b0;
            else if (div_ff == 3'h7) own_clk_ff <= ~own_clk_ff;
            if (pin_clk != clk_prev_ff && pin_clk != POLARITY) begin
                // New bit on the launch edge, settled by the sample edge
                data_ff <= ~data_ff;
            end
        end
    end
endmodule // sbcp_partner

/* File: verification/serial_baud_and_clock_polarity_tb_top.sv */
// Self-checking bench for the baud prescaler and clock polarity block
`timescale 1ns/1ns
module serial_baud_and_clock_polarity_tb_top;
    import sbcp_pkg::*;
    typedef struct {
        bit          wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } sbcp_row_t;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, tx_data = 0, serial_tx, serial_rx;
    logic [1:0]  mode = 2'h0;
    logic        dbl = 0, pol = 0, run = 0, sck_i, sck_o, sck_oe;
    logic        baud_tick, bit_tick, tx_launch, rx_sample, rx_bit;
    wire         pin_lvl = sck_oe ? sck_o : sck_i;
    int          errors = 0, n_compared = 0, cycles = 0, n;
    sbcp_row_t   rows[9] = '{
        '{0, 12'h000, 32'h0, 32'h0, 0},
        '{0, 12'h004, 32'h0, 32'h0, 0},
        '{1, 12'h000, 32'hffffffff, 32'h0, 0},
        '{0, 12'h000, 32'h0, 32'h0000000f, 0},
        '{1, 12'h004, 32'h000000a5, 32'h0, 0},
        '{0, 12'h004, 32'h0, 32'h000000a5, 0},
        '{0, 12'h010, 32'h0, 32'h0, 1},
        '{1, 12'h010, 32'h0, 32'h0, 1},
        '{1, 12'h00c, 32'h0, 32'h0, 0}
    };
    sbcp_top #(.DIV_W(12)) uut (
        .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MODE(mode),
        .DOUBLE_SPEED(dbl), .TX_DATA(tx_data), .SERIAL_TX(serial_tx),
        .SERIAL_RX(serial_rx), .SYNC_CLOCK_I(sck_i), .SYNC_CLOCK_O(sck_o),
        .SYNC_CLOCK_OE(sck_oe), .BAUD_TICK(baud_tick), .BIT_TICK(bit_tick),
        .TX_LAUNCH(tx_launch), .RX_SAMPLE(rx_sample), .RX_BIT(rx_bit)
    );
    sbcp_partner peer (
        .CLOCK(clock), .RST(rst), .SYNC_CLOCK_O(sck_o),
        .SYNC_CLOCK_OE(sck_oe), .POLARITY(pol), .RUN_CLOCK(run),
        .SERIAL_RX(serial_rx),
        .SYNC_CLOCK_I(sck_i)
    );
    always #50 clock = ~clock;
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH %0t run did not finish", $time);
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    // Waits on pready without assuming a latency; the timeout ends a hang
    task automatic apb(input bit wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles from one pulse of the chosen tick to the next
    task automatic gap(input bit bit_sel, output int p);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while ((bit_sel ? bit_tick : baud_tick) !== 1'b1 && k < 400);
        p = 0;
        do begin
            @(posedge clock);
            p++;
        end while ((bit_sel ? bit_tick : baud_tick) !== 1'b1 && p < 400);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            check({31'h0, er}, {31'h0, rows[i].err}, "slave error");
            if (!rows[i].wr) check(rd, rows[i].rdata, "read");
        end
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        apb(0, 12'h000, 32'h0);
        check(rd, 32'h0, "high after reset");
        apb(0, 12'h004, 32'h0);
        check(rd, 32'h0, "low after reset");
        gap(0, n);
        check(n, 1, "zero divisor period");
        apb(1, 12'h000, 32'h1);
        apb(1, 12'h004, 32'h0);
        gap(0, n);
        check(n, 257, "divisor period");
        apb(1, 12'h000, 32'h0);
        apb(1, 12'h004, 32'h3);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (baud_tick !== 1'b1 && n < 300);
        check(n <= 6, 1, "prompt reload");
        gap(0, n);
        check(n, 4, "reloaded period");
        apb(1, 12'h008, 32'h0); // Polarity kept zero for async
        apb(1, 12'h004, 32'h1);
        for (int i = 0; i < 4; i++) begin
            mode <= i[1] ? 2'h2 : 2'h0;
            dbl  <= i[0];
            gap(1, n);
            gap(1, n);
            check(n, i[0] ? 16 : 32, "bit period");
        end
        dbl <= 1'b0;
        apb(1, 12'h004, 32'h7); // Divisor set while no frame runs
        for (int j = 0; j < 6; j++) begin
            // Passes 4 and 5 run as slave, the peer driving the clock
            mode    <= (j < 4 && j[1]) ? 2'h3 : 2'h1;
            pol     <= j[0];
            run     <= (j >= 4);
            tx_data <= ~j[0];
            apb(1, 12'h008, {30'h0, j < 4, j[0]});
            repeat (20) @(posedge clock);
            n = 0;
            repeat (64) begin
                @(posedge clock);
                if (tx_launch === 1'b1) begin
                    n++;
                    check(pin_lvl, pol ? 32'h0 : 32'h1, "launch edge");
                    check(serial_tx, tx_data, "tx data");
                    tx_data <= ~tx_data;
                end
                if (rx_sample === 1'b1) begin
                    check(pin_lvl, pol, "sample edge");
                    check(rx_bit, serial_rx, "rx data");
                end
            end
            check(n != 0 && sck_oe === (j < 4), 1, "clock driven");
        end
        report_and_stop();
    end
endmodule // serial_baud_and_clock_polarity_tb_top
